// file: include/pbc_pkg.sv
// package: constants for the basic control low bits block
`default_nettype none
package pbc_pkg;
  localparam logic [4:0] REG_BASIC_MODE_CONTROL = 5'h00;
  localparam int BIT_RESTART = 9;
  localparam int BIT_DUPLEX = 8;
  localparam int BIT_COL_TEST = 7;
  localparam int BIT_AN_ENABLE = 12;
  localparam int BIT_SPEED = 13;
  localparam logic RST_COL_TEST = 1'b0;
  localparam logic RST_RESTART = 1'b0;
  localparam int CLK_NS = 100;
  // bit time at 10 Mb/s is 100 ns
  localparam int BIT_TIME_NS = 100;
  localparam int COL_ON_MAX_NS = 512 * BIT_TIME_NS;
  localparam int COL_OFF_MAX_NS = 4 * BIT_TIME_NS;
  localparam int COL_ON_MAX_CYC = COL_ON_MAX_NS / CLK_NS;
  localparam int COL_OFF_MAX_CYC = COL_OFF_MAX_NS / CLK_NS;
endpackage
`default_nettype wire

// file: hdl/pbc_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pbc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: hdl/pbc_basic_control.sv
// basic mode control register, bits 9 down to 0, with collision test
// Behaviour
// - writing one to bit 9 restarts auto-negotiation from the beginning
// - restart write ignored while auto-negotiation enable bit 12 is zero
// - restart bit reads 1 until negotiation starts, then self-clears
// - writing zero to restart does not disturb a running negotiation
// - with negotiation off, bit 8 selects full (1) or half (0) duplex
// - collision test: col asserted within 512 bit times of tx enable
// - collision test: col dropped within 4 bit times of tx enable low
// - bits 6:0 reserved, writes discarded, read as zero
// - negotiation disabled: speed and duplex bits fix the port mode
// - negotiation enabled: speed and duplex bits are disregarded
`timescale 1ns/1ps
`default_nettype none
module pbc_basic_control (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // register access from the management interface
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [9:0] reg_rdata_o,
  // neighbouring register bits
  input wire logic an_enable_i,
  input wire logic speed_bit_i,
  // strap pin
  input wire logic duplex_strap_i,
  // negotiation engine
  input wire logic an_started_i,
  input wire logic an_result_full_i,
  input wire logic an_result_fast_i,
  output logic an_restart_o,
  // resolved port mode
  output logic port_full_duplex_o,
  output logic port_fast_o,
  // mii pins
  input wire logic mii_tx_en_i,
  output logic mii_col_o
);
  typedef enum logic [3:0] {
    PBC_SYNC_A = 4'b0001,
    PBC_SYNC_B = 4'b0010,
    PBC_STRAP = 4'b0100,
    PBC_RUN = 4'b1000
  } pbc_phase_t;

  typedef struct packed {
    pbc_phase_t phase;
    logic restart;
    logic duplex;
    logic col_test;
    logic an_restart;
    logic full;
    logic fast;
    logic col;
    logic [9:0] rdata;
  } pbc_state_t;

  pbc_state_t s_q, s_d;
  logic tx_en_s;
  logic strap_s;
  logic wr_hit;

  pbc_sync2 #(.WIDTH(2)) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .async_i({mii_tx_en_i, duplex_strap_i}),
    .sync_o({tx_en_s, strap_s})
  );

  assign wr_hit = reg_wr_i && (reg_addr_i == pbc_pkg::REG_BASIC_MODE_CONTROL);

  always_comb begin
    s_d = s_q;
    s_d.an_restart = 1'b0;
    unique case (s_q.phase)
      PBC_SYNC_A: begin
        // strap still crossing the synchroniser
        s_d.phase = PBC_SYNC_B;
      end
      PBC_SYNC_B: begin
        s_d.phase = PBC_STRAP;
      end
      PBC_STRAP: begin
        // strap caught after reset release, synchronised
        s_d.duplex = strap_s;
        s_d.phase = PBC_RUN;
      end
      PBC_RUN: begin
        if (wr_hit) begin
          s_d.duplex = reg_wdata_i[pbc_pkg::BIT_DUPLEX];
          s_d.col_test = reg_wdata_i[pbc_pkg::BIT_COL_TEST];
          // zero write leaves restart untouched
          if (reg_wdata_i[pbc_pkg::BIT_RESTART] && an_enable_i) begin
            s_d.restart = 1'b1;
            s_d.an_restart = 1'b1;
          end
        end
        // set wins over completion in the same cycle
        if (s_q.restart && an_started_i && !s_d.an_restart) begin
          s_d.restart = 1'b0;
        end
      end
      default: s_d.phase = PBC_SYNC_A;
    endcase
    if (an_enable_i) begin
      s_d.full = an_result_full_i;
      s_d.fast = an_result_fast_i;
    end else begin
      s_d.full = s_d.duplex;
      s_d.fast = speed_bit_i;
    end
    // col follows tx enable in two to three cycles
    s_d.col = s_q.col_test && tx_en_s;
    s_d.rdata = '0;
    s_d.rdata[pbc_pkg::BIT_RESTART] = s_d.restart;
    s_d.rdata[pbc_pkg::BIT_DUPLEX] = s_d.duplex;
    s_d.rdata[pbc_pkg::BIT_COL_TEST] = s_d.col_test;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s_q.phase <= PBC_SYNC_A;
      s_q.restart <= pbc_pkg::RST_RESTART;
      s_q.duplex <= 1'b0;
      s_q.col_test <= pbc_pkg::RST_COL_TEST;
      s_q.an_restart <= 1'b0;
      s_q.full <= 1'b0;
      s_q.fast <= 1'b0;
      s_q.col <= 1'b0;
      s_q.rdata <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign an_restart_o = s_q.an_restart;
  assign port_full_duplex_o = s_q.full;
  assign port_fast_o = s_q.fast;
  assign mii_col_o = s_q.col;

  // helper counters for collision timing
  logic [9:0] on_cnt_q;
  logic [3:0] off_cnt_q;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      on_cnt_q <= '0;
      off_cnt_q <= '0;
    end else begin
      on_cnt_q <= (mii_tx_en_i && s_q.col_test && !s_q.col) ?
        on_cnt_q + 10'h001 : 10'h000;
      off_cnt_q <= (!mii_tx_en_i && s_q.col) ? off_cnt_q + 4'h1 : 4'h0;
    end
  end

  chk_col_on_time: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    on_cnt_q <= 10'(pbc_pkg::COL_ON_MAX_CYC))
    else $error("col late after tx enable");
  chk_col_off_time: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    off_cnt_q <= 4'(pbc_pkg::COL_OFF_MAX_CYC))
    else $error("col late to drop");
  chk_col_needs_test: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    !s_q.col_test |=> !mii_col_o)
    else $error("col without test mode");
  chk_col_follow: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (s_q.col_test && tx_en_s) |=> mii_col_o)
    else $error("col did not follow tx enable");
  chk_restart_ignored: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (wr_hit && !an_enable_i && !s_q.restart) |=> !an_restart_o)
    else $error("restart taken with negotiation off");
  chk_restart_pulse: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (s_q.phase == PBC_RUN && wr_hit && an_enable_i
      && reg_wdata_i[pbc_pkg::BIT_RESTART]) |=> an_restart_o
      && reg_rdata_o[pbc_pkg::BIT_RESTART])
    else $error("restart not issued");
  chk_restart_hold: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (s_q.restart && !an_started_i) |=> s_q.restart)
    else $error("restart bit cleared early");
  chk_restart_clear: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (s_q.restart && an_started_i && !wr_hit) |=> !s_q.restart)
    else $error("restart bit did not self clear");
  chk_zero_write: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (s_q.restart && !an_started_i && wr_hit) |=> s_q.restart)
    else $error("zero write disturbed restart");
  chk_reserved_zero: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_rdata_o[6:0] == 7'h00)
    else $error("reserved bits not zero");
  chk_duplex_write: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (s_q.phase == PBC_RUN && wr_hit) |=>
      reg_rdata_o[pbc_pkg::BIT_DUPLEX]
        == $past(reg_wdata_i[pbc_pkg::BIT_DUPLEX]))
    else $error("duplex bit not stored");
  chk_forced_duplex: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (!an_enable_i && s_q.phase == PBC_RUN && !wr_hit)[*2] |->
      port_full_duplex_o == s_q.duplex && port_fast_o == $past(speed_bit_i))
    else $error("forced mode wrong");
  chk_an_mode: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    an_enable_i |=> port_full_duplex_o == $past(an_result_full_i))
    else $error("negotiated duplex wrong");
  chk_strap_load: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    s_q.phase == PBC_STRAP |=> s_q.duplex == $past(strap_s))
    else $error("strap not loaded");
endmodule
`default_nettype wire

// file: testbench/pbc_engine_model.sv
// negotiation engine stand-in: answers a restart after a delay
`timescale 1ns/1ps
`default_nettype none
module pbc_engine_model #(
  parameter int DELAY = 6
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // engine side
  input wire logic an_restart_i,
  output logic an_started_o,
  output logic an_result_full_o,
  output logic an_result_fast_o
);
  int cnt;
  assign an_result_full_o = 1'b1;
  assign an_result_fast_o = 1'b1;
  always @(negedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= 0;
      an_started_o <= 1'b0;
    end else begin
      an_started_o <= (cnt == 1);
      if (an_restart_i) begin
        cnt <= DELAY;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// testbench for the basic control low bits block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic [4:0] reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic an_en = 1'b1;
  logic spd = 1'b0;
  logic strap = 1'b1;
  logic tx_en = 1'b0;
  logic [9:0] reg_rdata_o;
  logic an_restart_o, mii_col_o, full, fast, started, rfull, rfast;
  int n_mismatch = 0;
  int check_count = 0;
  int n_rst = 0;
  int k;
  pbc_basic_control pbc_basic_control_inst (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .an_enable_i(an_en), .speed_bit_i(spd), .duplex_strap_i(strap),
    .an_started_i(started), .an_result_full_i(rfull),
    .an_result_fast_i(rfast), .an_restart_o(an_restart_o),
    .port_full_duplex_o(full), .port_fast_o(fast),
    .mii_tx_en_i(tx_en), .mii_col_o(mii_col_o));
  pbc_engine_model pbc_engine_model_inst (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .an_restart_i(an_restart_o),
    .an_started_o(started), .an_result_full_o(rfull),
    .an_result_fast_o(rfast));
  initial forever #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (an_restart_o === 1'b1) n_rst++;
  task end_sim();
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task wr(input logic [15:0] d);
    @(negedge clk_sys_i);
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
  endtask
  task automatic waitv(input bit w, input logic v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      if ((w ? mii_col_o : reg_rdata_o[9]) === v) break;
      @(negedge clk_sys_i);
    end
    chk(i < n, "wait ran out");
    if (i >= n) end_sim();
  endtask
  task t_restart();
    k = n_rst;
    wr(16'h0200);
    chk(n_rst == k + 1, "no restart pulse");
    chk(reg_rdata_o[9] === 1'b1, "restart bit not held");
    wr(16'h0000);
    chk(reg_rdata_o[9] === 1'b1, "restart bit cleared by write");
    waitv(1'b0, 1'b0, 20);
    chk(n_rst == k + 1, "negotiation disturbed");
  endtask
  task t_ignored();
    an_en = 1'b0;
    k = n_rst;
    wr(16'h0200);
    chk(n_rst == k && reg_rdata_o[9] === 1'b0, "restart not ignored");
  endtask
  task t_mode();
    spd = 1'b1;
    wr(16'h007f);
    chk(reg_rdata_o === 10'h000, "reserved bits not zero");
    chk(full === 1'b0 && fast === 1'b1, "forced mode wrong");
    wr(16'h0100);
    chk(full === 1'b1, "full duplex not set");
    spd = 1'b0;
    wr(16'h0000);
    an_en = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk(full === 1'b1 && fast === 1'b1, "bits not disregarded");
  endtask
  task t_col();
    tx_en = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    chk(mii_col_o === 1'b0, "collision without test");
    tx_en = 1'b0;
    wr(16'h0080);
    tx_en = 1'b1;
    waitv(1'b1, 1'b1, 512);
    tx_en = 1'b0;
    waitv(1'b1, 1'b0, 4);
  endtask
  task t_strap();
    strap = 1'b0;
    @(negedge clk_sys_i);
    reset_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    reset_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    chk(reg_rdata_o === 10'h000, "strap low not taken");
  endtask
  initial begin
    repeat (20) @(negedge clk_sys_i);
    reset_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk(reg_rdata_o === 10'h100, "reset value wrong");
    t_restart();
    t_ignored();
    t_mode();
    t_col();
    t_strap();
    end_sim();
  end
endmodule
`default_nettype wire
